// file: hw/scoc_regs.svh
// constants of the skew clock output control block
`ifndef SCOC_REGS_SVH
`define SCOC_REGS_SVH
// sample delay line: depth and the tap that means zero skew
`define SCOC_DLY_DEPTH 64
`define SCOC_DLY_OFFSET 8'sh18
// skew step unit in sample cycles for range low, mid, high
`define SCOC_TU_LOW 7'sh01
`define SCOC_TU_MID 7'sh02
`define SCOC_TU_HIGH 7'sh04
// matched reference periods needed before lock is shown
`define SCOC_LOCK_COUNT 5'h10
// bank that keeps running while the others are stopped
`define SCOC_FEEDBACK_BANK 1
`define SCOC_NUM_BANKS 4
`endif

// file: hw/scoc_pkg.sv
// types of the skew clock output control block
`default_nettype none
package scoc_pkg;
   // three-level strap input; open means left undriven
   typedef enum logic [1:0] {LVL_LOW = 2'h0, LVL_MID = 2'h1, LVL_HIGH = 2'h2,
      LVL_OPEN = 2'h3} scoc_lvl_t;
   // two three-level selects of one bank
   typedef struct packed {
      scoc_lvl_t hi;
      scoc_lvl_t lo;
   } scoc_sel_t;
   // function of one bank
   typedef enum logic [3:0] {MODE_SKEW = 4'h1, MODE_DIV2 = 4'h2, MODE_DIV4 = 4'h4,
      MODE_INV = 4'h8} scoc_mode_t;
   // phase lock tracker
   typedef enum logic [2:0] {LK_LOST = 3'h1, LK_TRACK = 3'h2,
      LK_LOCKED = 3'h4} scoc_lock_t;
endpackage : scoc_pkg
`default_nettype wire

// file: hw/scoc_top.sv
// skew clock output control: skew taps, dividers, sync enables, lock flag
//
// Contract
// - With the sync output enable input low every output is enabled, synchronously.
// - With that input high all outputs but bank 2 stop synchronously, low for rising polarity.
// - Bank 2 keeps toggling while others stop so it can serve as feedback.
// - A lock output asserts once reference and feedback are phase locked.
// - Polarity high aligns outputs to reference rising edges, low to falling edges.
// - The polarity select defaults to rising edges when left undriven.
// - Bypass at high, or at mid with enable input low, disables the loop and passes the reference, skews kept.
// - Bypass mid with enable input high keeps the loop and disables any bank set low-low.
// - Eight outputs form four banks of two that share one setting per bank.
// - Each bank decodes two three-level selects into nine skews or functions.
// - An undriven three-level select counts as mid, giving zero skew.
// - Banks 1-2 skew -4..+4 units; banks 3-4 skew -6..+6 by two, with divide and invert ends.
// - The skew unit is 1/128, 1/64 or 1/32 of the nominal period for range low, mid, high.
// - Inverted bank 4 is held high when disabled under rising polarity, else low.
`timescale 1ns/1ps
`default_nettype none
`include "scoc_regs.svh"

module scoc_top
   import scoc_pkg::*;
(
   // clock and reset
   input wire logic MCLK_IN,
   input wire logic RST_B_IN,
   // reference and feedback clocks
   input wire logic REF_CLOCK_IN,
   input wire logic FEEDBACK_CLOCK_IN,
   // straps and controls
   input wire logic SYNC_OUTPUT_ENABLE_N_IN,
   input wire logic EDGE_POLARITY_SELECT_IN,
   input wire logic EDGE_POLARITY_DRIVEN_IN,
   input wire scoc_lvl_t BYPASS_SELECT_IN,
   input wire scoc_lvl_t VCO_RANGE_SELECT_IN,
   input wire scoc_sel_t [3:0] BANK_SKEW_SELECT_IN,
   // clock outputs and status
   output logic [7:0] BANK_CLOCK_OUT,
   output logic LOCK_OUT
);

   // ----------------------------------------------------------------
   // shared controls and reference delay line
   // ----------------------------------------------------------------
   logic [`SCOC_DLY_DEPTH-1:0] dly, next_dly;
   logic [1:0] div_cnt, next_div_cnt;
   logic pe_eff, pll_off, oe_n, zs_rise, zs_late;
   scoc_lvl_t byp, rng;
   logic signed [6:0] tu;

   function automatic logic [3:0] lvl_val(input scoc_lvl_t l);
      lvl_val = (l == LVL_LOW) ? 4'h0 : (l == LVL_HIGH) ? 4'h2 : 4'h1;
   endfunction : lvl_val

   // straps, step unit and next delay line
   always_comb
   begin
      oe_n = SYNC_OUTPUT_ENABLE_N_IN;
      pe_eff = EDGE_POLARITY_DRIVEN_IN ? EDGE_POLARITY_SELECT_IN : 1'b1;
      byp = (BYPASS_SELECT_IN == LVL_OPEN) ? LVL_MID : BYPASS_SELECT_IN;
      rng = (VCO_RANGE_SELECT_IN == LVL_OPEN) ? LVL_MID : VCO_RANGE_SELECT_IN;
      case (rng)
         LVL_LOW: tu = `SCOC_TU_LOW;
         LVL_MID: tu = `SCOC_TU_MID;
         default: tu = `SCOC_TU_HIGH;
      endcase
      pll_off = (byp == LVL_HIGH) || (byp == LVL_MID && !oe_n);
      next_dly = {dly[`SCOC_DLY_DEPTH-2:0], pe_eff ? REF_CLOCK_IN : ~REF_CLOCK_IN};
      zs_rise = dly[6'(`SCOC_DLY_OFFSET)] && !dly[6'(`SCOC_DLY_OFFSET + 8'sh01)];
      // same edge one cycle on, so a zero skew feedback rise is already in the history
      zs_late = dly[6'(`SCOC_DLY_OFFSET + 8'sh01)] && !dly[6'(`SCOC_DLY_OFFSET + 8'sh02)];
      next_div_cnt = div_cnt + {1'b0, zs_rise};
   end

   // register delay line and divider
   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         dly <= '0;
         div_cnt <= 2'h0;
      end
      else
      begin
         dly <= next_dly;
         div_cnt <= next_div_cnt;
      end
   end

   // ----------------------------------------------------------------
   // per bank decode, synchronous enable and output flop
   // ----------------------------------------------------------------
   scoc_mode_t mode [4];
   logic [5:0] tap [4];
   logic [3:0] idx [4];
   logic [3:0] raw, rest, en, next_en, q, next_q, ll_off;

   genvar g;
   generate
      for (g = 0; g < `SCOC_NUM_BANKS; g++)
      begin : g_bank
         logic signed [4:0] steps;
         logic signed [7:0] delta;
         logic want_en;

         // decode nine settings and pick the source
         always_comb
         begin
            idx[g] = 4'(lvl_val(BANK_SKEW_SELECT_IN[g].hi) * 4'h3) +
               lvl_val(BANK_SKEW_SELECT_IN[g].lo);
            steps = $signed({1'b0, idx[g]}) - 5'sh04;
            if (g >= 2)
               steps = steps <<< 1;
            mode[g] = MODE_SKEW;
            if (g >= 2 && idx[g] == 4'h0)
               mode[g] = MODE_DIV2;
            else if (g == 2 && idx[g] == 4'h8)
               mode[g] = MODE_DIV4;
            else if (g == 3 && idx[g] == 4'h8)
               mode[g] = MODE_INV;
            delta = (mode[g] == MODE_SKEW) ? 8'(steps * tu) : 8'sh00;
            tap[g] = 6'(`SCOC_DLY_OFFSET + delta);
            case (mode[g])
               MODE_DIV2: raw[g] = div_cnt[0];
               MODE_DIV4: raw[g] = div_cnt[1];
               MODE_INV: raw[g] = ~dly[tap[g]];
               default: raw[g] = dly[tap[g]];
            endcase
            rest[g] = (mode[g] == MODE_INV) ? pe_eff : ~pe_eff;
            ll_off[g] = (byp == LVL_MID) && oe_n && (idx[g] == 4'h0);
            want_en = !(oe_n && g != `SCOC_FEEDBACK_BANK) && !ll_off[g];
            next_en[g] = (raw[g] == rest[g]) ? want_en : en[g];
            next_q[g] = en[g] ? raw[g] : rest[g];
         end

         // register enable and output level
         always_ff @(posedge MCLK_IN or negedge RST_B_IN)
         begin
            if (!RST_B_IN)
            begin
               en[g] <= 1'b1;
               q[g] <= 1'b0;
            end
            else
            begin
               en[g] <= next_en[g];
               q[g] <= next_q[g];
            end
         end

         assign BANK_CLOCK_OUT[2*g+1:2*g] = {2{q[g]}}; // both outputs of a bank
      end
   endgenerate

   // ----------------------------------------------------------------
   // phase lock tracker
   // ----------------------------------------------------------------
   scoc_lock_t lk_state, next_lk_state;
   logic [4:0] lk_cnt, next_lk_cnt;
   logic [2:0] fb_hist, next_fb_hist;
   logic fb_q, zs_rise_q, match, next_lock;

   // compare feedback edges with the zero skew edge within a three cycle window
   always_comb
   begin
      next_fb_hist = {fb_hist[1:0], FEEDBACK_CLOCK_IN && !fb_q};
      match = |fb_hist;
      next_lk_state = lk_state;
      next_lk_cnt = lk_cnt;
      case (lk_state)
         LK_LOST:
            if (zs_rise_q && match)
            begin
               next_lk_state = LK_TRACK;
               next_lk_cnt = 5'h01;
            end
         LK_TRACK:
            if (zs_rise_q && !match)
               next_lk_state = LK_LOST;
            else if (zs_rise_q)
            begin
               next_lk_cnt = lk_cnt + 5'h01;
               if (lk_cnt + 5'h01 == `SCOC_LOCK_COUNT)
                  next_lk_state = LK_LOCKED;
            end
         LK_LOCKED:
            if (zs_rise_q && !match)
               next_lk_state = LK_LOST;
         default:
            next_lk_state = LK_LOST;
      endcase
      if (pll_off)
         next_lk_state = LK_LOST;
      next_lock = (next_lk_state == LK_LOCKED);
   end

   // register tracker state
   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         lk_state <= LK_LOST;
         lk_cnt <= 5'h00;
         fb_hist <= 3'h0;
         fb_q <= 1'b0;
         zs_rise_q <= 1'b0;
         LOCK_OUT <= 1'b0;
      end
      else
      begin
         lk_state <= next_lk_state;
         lk_cnt <= next_lk_cnt;
         fb_hist <= next_fb_hist;
         fb_q <= FEEDBACK_CLOCK_IN;
         zs_rise_q <= zs_late;
         LOCK_OUT <= next_lock;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_B_IN);

   property p_enable;
      !oe_n && raw[0] == rest[0] |=> en[0];
   endproperty
   a_enable: assert property (p_enable) else $error("bank 1 not enabled");
   property p_stop;
      !en[2] |=> BANK_CLOCK_OUT[4] == $past(rest[2]) && BANK_CLOCK_OUT[5] == BANK_CLOCK_OUT[4];
   endproperty
   a_stop: assert property (p_stop) else $error("stopped bank 3 not at rest");
   property p_feedback;
      en[1] && oe_n && !ll_off[1] |=> en[1];
   endproperty
   a_feedback: assert property (p_feedback) else $error("bank 2 stopped");
   property p_lock;
      $rose(LOCK_OUT) |-> $past(lk_state) == LK_TRACK && $past(lk_cnt) == 5'h0F;
   endproperty
   a_lock: assert property (p_lock) else $error("lock without full count");
   property p_polarity;
      (pe_eff && $rose(REF_CLOCK_IN)) or (!pe_eff && $fell(REF_CLOCK_IN)) |=> dly[0];
   endproperty
   a_polarity: assert property (p_polarity) else $error("wrong reference edge");
   property p_pullup;
      !EDGE_POLARITY_DRIVEN_IN && $rose(REF_CLOCK_IN) |=> dly[0];
   endproperty
   a_pullup: assert property (p_pullup) else $error("polarity default wrong");
   property p_bypass;
      pll_off |=> !LOCK_OUT ##1 !LOCK_OUT;
   endproperty
   a_bypass: assert property (p_bypass) else $error("lock shown in bypass");
   property p_bankoff;
      byp == LVL_MID && oe_n && idx[1] == 4'h0 && raw[1] == rest[1] |=> !en[1];
   endproperty
   a_bankoff: assert property (p_bankoff) else $error("low-low bank not off");
   property p_decode;
      idx[3] == 4'h8 |-> mode[3] == MODE_INV && mode[1] == MODE_SKEW;
   endproperty
   a_decode: assert property (p_decode) else $error("bank 4 decode wrong");
   property p_open;
      BANK_SKEW_SELECT_IN[0] == {LVL_OPEN, LVL_OPEN} |-> tap[0] == 6'h18;
   endproperty
   a_open: assert property (p_open) else $error("open select not zero skew");
   property p_unit;
      idx[0] == 4'h8 && rng == LVL_HIGH |-> tap[0] == 6'h28;
   endproperty
   a_unit: assert property (p_unit) else $error("step unit wrong");
   property p_inv;
      mode[3] == MODE_INV && !en[3] |=> BANK_CLOCK_OUT[6] == $past(pe_eff);
   endproperty
   a_inv: assert property (p_inv) else $error("inverted bank 4 rest wrong");
   property p_glitch;
      $changed(en[0]) |-> $past(raw[0]) == $past(rest[0]);
   endproperty
   a_glitch: assert property (p_glitch) else $error("enable changed mid period");

endmodule : scoc_top
`default_nettype wire

// file: verification/scoc_ref_src.sv
// reference source model with the feedback loop closed from bank 2
`timescale 1ns/1ps
`default_nettype none
module scoc_ref_src #(parameter int HALF = 64)
(
   // timing
   input wire logic mclk_in,
   // scenario controls and returned outputs
   input wire logic fb_break_in,
   input wire logic [7:0] bank_clock_in,
   // clocks into the device
   output logic ref_clock_out,
   output logic feedback_clock_out
);
   int cnt = 0;
   // free running reference, toggled off the sampling edge
   initial ref_clock_out = 1'b0;
   always @(negedge mclk_in)
   begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
         ref_clock_out <= ~ref_clock_out;
   end
   // bank 2 returned as feedback; a broken loop reads low
   assign feedback_clock_out = bank_clock_in[2] & ~fb_break_in;
endmodule : scoc_ref_src
`default_nettype wire

// file: verification/scoc_top_tb.sv
// self-checking bench of the skew clock output control
`timescale 1ns/1ps
`default_nettype none
module scoc_top_tb;
   import scoc_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic oe_n = 1'b0;
   logic pol = 1'b1;
   logic pol_drv = 1'b1;
   logic brk = 1'b0;
   scoc_lvl_t byp = LVL_LOW;
   scoc_lvl_t rng = LVL_LOW;
   scoc_sel_t [3:0] sel = 16'h5555;
   logic ref_clk;
   logic fb_clk;
   logic [7:0] q;
   logic lock;
   int error_cnt = 0;
   int comparisons = 0;
   int dly [8];
   int rises [8];
   int units [3] = '{1, 2, 4};
   // ----------------
   // clock and parts
   // ----------------
   initial forever #12.5 mclk = ~mclk;
   scoc_top scoc_top_i (.MCLK_IN(mclk), .RST_B_IN(rst_b), .REF_CLOCK_IN(ref_clk),
      .FEEDBACK_CLOCK_IN(fb_clk), .SYNC_OUTPUT_ENABLE_N_IN(oe_n),
      .EDGE_POLARITY_SELECT_IN(pol), .EDGE_POLARITY_DRIVEN_IN(pol_drv),
      .BYPASS_SELECT_IN(byp), .VCO_RANGE_SELECT_IN(rng),
      .BANK_SKEW_SELECT_IN(sel), .BANK_CLOCK_OUT(q), .LOCK_OUT(lock));
   scoc_ref_src scoc_ref_src_i (.mclk_in(mclk), .fb_break_in(brk),
      .bank_clock_in(q), .ref_clock_out(ref_clk), .feedback_clock_out(fb_clk));
   // ----------------
   // shared tasks
   // ----------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // same select code on every bank
   task automatic set_sel(input int idx);
      scoc_sel_t s;
      @(negedge mclk);
      s = '{hi: scoc_lvl_t'(idx / 3), lo: scoc_lvl_t'(idx % 3)};
      sel = {4{s}};
   endtask : set_sel
   // edges from a reference edge to the first rise of each output
   task automatic measure(input logic lvl);
      logic [7:0] prev;
      @(negedge mclk);
      wait (ref_clk !== lvl);
      wait (ref_clk === lvl);
      dly = '{default: 0};
      prev = q;
      for (int n = 1; n < 110; n++)
      begin
         @(negedge mclk);
         foreach (dly[b])
            if (q[b] === 1'b1 && prev[b] !== 1'b1 && dly[b] == 0)
               dly[b] = n;
         prev = q;
      end
   endtask : measure
   // rising edges of each output over a span
   task automatic count(input int cycles);
      logic [7:0] prev;
      prev = q;
      rises = '{default: 0};
      repeat (cycles)
      begin
         @(negedge mclk);
         foreach (rises[b])
            if (q[b] === 1'b1 && prev[b] !== 1'b1)
               rises[b]++;
         prev = q;
      end
   endtask : count
   task automatic wait_lock;
      for (int n = 0; n < 4000 && lock !== 1'b1; n++)
         @(negedge mclk);
   endtask : wait_lock
   // ----------------
   // scenarios
   // ----------------
   initial
   begin
      repeat (10) @(negedge mclk);
      check(lock, 1'b0);
      rst_b = 1'b1;
      wait_lock();
      check(lock, 1'b1);
      byp = LVL_HIGH;
      repeat (3) @(negedge mclk);
      check(lock, 1'b0);
      measure(1'b1);
      check(16'(dly[0]), 16'd26);
      byp = LVL_LOW;
      wait_lock();
      brk = 1'b1;
      count(400);
      check(lock, 1'b0);
      brk = 1'b0;
      // every range against every select code
      foreach (units[r])
      begin
         rng = scoc_lvl_t'(r);
         for (int idx = 0; idx < 9; idx++)
         begin
            set_sel(idx);
            measure(1'b1);
            for (int b = 0; b < 4; b++)
               check(16'(dly[b]), 16'(26 + (idx - 4) * units[r]));
            for (int b = 4; b < 8; b++)
               if (idx > 0 && idx < 8)
                  check(16'(dly[b]), 16'(26 + 2 * (idx - 4) * units[r]));
            if (idx == 8)
               check(16'(dly[7]), 16'd90);
         end
      end
      sel = 16'hFFFF;
      rng = LVL_OPEN;
      measure(1'b1);
      foreach (dly[b])
         check(16'(dly[b]), 16'd26);
      pol = 1'b0;
      count(130);
      measure(1'b0);
      check(16'(dly[0]), 16'd26);
      pol_drv = 1'b0;
      count(130);
      measure(1'b1);
      check(16'(dly[2]), 16'd26);
      pol_drv = 1'b1;
      pol = 1'b1;
      // divide by 2 on bank 4, then divide by 4 on bank 3 with bank 4 inverted
      sel = 16'h0555;
      count(600);
      count(512);
      check(16'(rises[6]), 16'd2);
      sel = 16'hAA55;
      count(600);
      count(512);
      check(16'(rises[4]), 16'd1);
      // synchronous stop with bank 4 inverted
      oe_n = 1'b1;
      count(300);
      count(512);
      check(16'(rises[0] + rises[4] + rises[6]), 16'd0);
      check(16'(rises[2]), 16'd4);
      check(q[0], 1'b0);
      check(q[6], 1'b1);
      byp = LVL_MID;
      sel[1] = '{hi: LVL_LOW, lo: LVL_LOW};
      count(300);
      count(512);
      check(16'(rises[2]), 16'd0);
      byp = LVL_LOW;
      oe_n = 1'b0;
      count(300);
      count(512);
      check(16'(rises[0] + rises[1]), 16'd8);
      close_out();
   end
   // watchdog well beyond the expected run
   initial
   begin
      #1ms;
      error_cnt++;
      close_out();
   end
endmodule : scoc_top_tb
`default_nettype wire
